// file: shared/scan_cfg_pkg.sv
// Constants and helpers shared by both ends of the converter setup link.
// Notes on behaviour
// RULE1 - Select code 10100 writes the upper-channel mask.
// RULE2 - Upper mask bits 10..3 enable inputs 15..8.
// RULE3 - Select code 10101 writes the lower-channel mask.
// RULE4 - Lower mask bits 10..3 enable inputs 7..0.
// RULE5 - Masks reset to zero; bits 2..0 unused.
// RULE6 - Select code 10110 writes the sequence length.
// RULE7 - Conversions per sequence equal length field plus one.
// RULE8 - Mode write starts; readout begins at first entry.
// RULE9 - Shutdown may be ordered during last readout.
// RULE10 - Host reloads whole pattern to change length.
// RULE11 - Top bit one means configuration word.
// RULE12 - Top bit zero means mode-control word.
// RULE13 - Mid-sequence mode word applies at next frame start.
// RULE14 - Mid-sequence configuration keeps the running scan.
// RULE15 - After mid-sequence configuration, output invalid until mode.
// RULE16 - Sixteen bits, top first, acted on at frame end.
// RULE17 - Unknown select codes are ignored.
`default_nettype none
package scan_cfg_pkg;
  localparam int WORD_W = 16;
  localparam int KIND_BIT = 15;
  localparam int CODE_HI = 15;
  localparam int CODE_LO = 11;
  localparam int FIELD_HI = 10;
  localparam int FIELD_LO = 3;
  localparam logic [4:0] UPPER_MASK_CODE = 5'h14;
  localparam logic [4:0] LOWER_MASK_CODE = 5'h15;
  localparam logic [4:0] SEQUENCE_CODE = 5'h16;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] LENGTH_RESET = 8'h00;
  localparam int MODE_START_BIT = 14;
  localparam int MODE_SHUTDOWN_BIT = 13;
  localparam logic [4:0] BITS_PER_WORD = 5'h10;
  // Serial clock half period, made by the host from its own clock.
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCLK_HALF_NS = 32;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] HALF_LAST = 4'(SCLK_HALF_CYC - 1);
  // Host register byte offsets and status bit positions.
  localparam logic [3:0] TX_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] RX_OFFSET = 4'h8;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_RX_BIT = 1;

  function automatic logic [4:0] word_code(input logic [15:0] w);
    word_code = w[CODE_HI:CODE_LO];
  endfunction : word_code

  function automatic logic [7:0] word_field(input logic [15:0] w);
    word_field = w[FIELD_HI:FIELD_LO];
  endfunction : word_field
endpackage : scan_cfg_pkg
`default_nettype wire

// file: shared/scan_link_if.sv
// Serial link between the host controller and the converter setup logic.
`timescale 1ns/1ps
`default_nettype none
interface scan_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;
  modport host (output sclk, output cs_n, output din, input dout);
  modport dev (input sclk, input cs_n, input din, output dout);
endinterface : scan_link_if
`default_nettype wire

// file: rtl/scan_cfg_device.sv
// Converter end: word decode, scan masks, sequence length and sequencing.
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module scan_cfg_device (
  input wire logic clock, // System clock.
  input wire logic rstn, // Asynchronous reset, active low.
  scan_link_if.dev link, // Serial link from the host.
  output logic conv_req, // One-cycle request for one conversion.
  output logic [3:0] conv_chan, // Input channel of the requested conversion.
  input wire logic [15:0] conv_result, // Result word, same clock, ready at request.
  output logic [7:0] upper_mask, // Stored enables for inputs 15..8.
  output logic [7:0] lower_mask, // Stored enables for inputs 7..0.
  output logic [7:0] sequence_length_field, // Stored length field.
  output logic seq_busy, // High while a sequence runs.
  output logic out_invalid, // High while output data is not valid.
  output logic shutdown // High while in automatic shutdown.
);
  // Link synchronisers; only stage two and three feed logic.
  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic din_s1_q, din_s2_q;
  logic [15:0] rx_q;
  logic [4:0] bit_cnt_q;
  logic [15:0] tx_q;
  logic [7:0] upper_q, lower_q, length_q;
  logic [15:0] act_mask_q;
  logic [8:0] act_total_q;
  logic [8:0] done_q;
  logic [3:0] chan_q;
  logic busy_q, invalid_q, shutdown_q, arm_q;
  logic pend_q, pend_start_q, pend_shdn_q;
  logic conv_req_q;

  // Next enabled channel after cur, searching upward with wrap.
  function automatic logic [3:0] next_chan(input logic [15:0] mask, input logic [3:0] cur);
    logic [3:0] idx;
    next_chan = cur;
    for (int i = 16; i >= 1; i--) begin
      idx = 4'(cur + 4'(i));
      if (mask[idx]) begin
        next_chan = idx;
      end
    end
  endfunction : next_chan

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {sclk_s1_q, sclk_s2_q, sclk_s3_q} <= 3'h0;
      {cs_s1_q, cs_s2_q, cs_s3_q} <= 3'h7;
      {din_s1_q, din_s2_q} <= 2'h0;
    end else begin
      {sclk_s1_q, sclk_s2_q, sclk_s3_q} <= {link.sclk, sclk_s1_q, sclk_s2_q};
      {cs_s1_q, cs_s2_q, cs_s3_q} <= {link.cs_n, cs_s1_q, cs_s2_q};
      {din_s1_q, din_s2_q} <= {link.din, din_s1_q};
    end
  end

  // Edge detection on the synchronised link signals.
  wire sclk_rise = sclk_s2_q & ~sclk_s3_q;
  wire sclk_fall = ~sclk_s2_q & sclk_s3_q;
  wire cs_fall = ~cs_s2_q & cs_s3_q;
  wire cs_rise = cs_s2_q & ~cs_s3_q;
  wire in_frame = ~cs_s2_q;

  // RULE16 whole word check
  wire frame_done = cs_rise & (bit_cnt_q == scan_cfg_pkg::BITS_PER_WORD);
  // RULE11 configuration kind
  wire is_cfg = frame_done & rx_q[scan_cfg_pkg::KIND_BIT];
  // RULE12 mode-control kind
  wire is_mode = frame_done & ~rx_q[scan_cfg_pkg::KIND_BIT];
  wire [4:0] code = scan_cfg_pkg::word_code(rx_q);
  wire [7:0] field = scan_cfg_pkg::word_field(rx_q);
  // RULE1 upper mask select
  wire wr_upper = is_cfg & (code == scan_cfg_pkg::UPPER_MASK_CODE);
  // RULE3 lower mask select
  wire wr_lower = is_cfg & (code == scan_cfg_pkg::LOWER_MASK_CODE);
  // RULE6 length select
  wire wr_length = is_cfg & (code == scan_cfg_pkg::SEQUENCE_CODE);
  wire mode_start = rx_q[scan_cfg_pkg::MODE_START_BIT];
  wire mode_shdn = rx_q[scan_cfg_pkg::MODE_SHUTDOWN_BIT];

  // RULE2 upper enables map to inputs 15..8
  // RULE4 lower enables map to inputs 7..0
  wire [15:0] live_mask = {upper_q, lower_q};
  // A start with no channel enabled has nothing to scan and is dropped.
  wire starting = cs_fall & pend_q & pend_start_q & (live_mask != 16'h0000);
  wire last_frame = busy_q & (done_q == act_total_q);
  // RULE14 continue with the latched scan
  wire converting = starting | (cs_fall & busy_q & ~pend_q & (done_q != act_total_q));
  wire [15:0] use_mask = starting ? live_mask : act_mask_q;
  wire [3:0] use_from = starting ? 4'hf : chan_q;
  wire [3:0] new_chan = next_chan(use_mask, use_from);

  // Serial input: sample on rising serial clock, count to sixteen.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_q <= 16'h0000;
      bit_cnt_q <= 5'h00;
    end else if (cs_fall) begin
      bit_cnt_q <= 5'h00;
    end else if (in_frame & sclk_rise) begin
      // RULE16 top bit first
      rx_q <= {rx_q[14:0], din_s2_q};
      if (bit_cnt_q != scan_cfg_pkg::BITS_PER_WORD) begin
        bit_cnt_q <= 5'(bit_cnt_q + 5'h01);
      end
    end
  end

  // Setup registers; any other code leaves them alone.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      // RULE5 channels start disabled
      upper_q <= scan_cfg_pkg::MASK_RESET;
      lower_q <= scan_cfg_pkg::MASK_RESET;
      length_q <= scan_cfg_pkg::LENGTH_RESET;
    end else begin
      // RULE17 unknown codes fall through
      if (wr_upper) begin
        upper_q <= field;
      end
      if (wr_lower) begin
        lower_q <= field;
      end
      if (wr_length) begin
        length_q <= field;
      end
    end
  end

  // Mode words other than a bare shutdown wait for the next frame start, even when idle.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pend_q <= 1'b0;
      pend_start_q <= 1'b0;
      pend_shdn_q <= 1'b0;
    end else if (is_mode & (mode_start | ~mode_shdn)) begin
      // RULE13 defer to next frame start
      pend_q <= 1'b1;
      pend_start_q <= mode_start;
      pend_shdn_q <= mode_shdn;
    end else if (cs_fall) begin
      pend_q <= 1'b0;
    end
  end

  // Sequence state: latched scan copy, progress and current channel.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 1'b0;
      act_mask_q <= 16'h0000;
      act_total_q <= 9'h000;
      done_q <= 9'h000;
      chan_q <= 4'h0;
      arm_q <= 1'b0;
    end else begin
      if (starting) begin
        // RULE8 begin at the first entry
        busy_q <= 1'b1;
        act_mask_q <= live_mask;
        // RULE7 length field plus one
        act_total_q <= 9'(length_q) + 9'h001;
        done_q <= 9'h001;
        chan_q <= new_chan;
        arm_q <= pend_shdn_q;
      end else if (cs_fall & pend_q) begin
        busy_q <= 1'b0;
        arm_q <= 1'b0;
      end else if (converting) begin
        done_q <= 9'(done_q + 9'h001);
        chan_q <= new_chan;
      end else if (cs_rise & last_frame) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Shutdown: armed by the start word or ordered while idle or during the last readout.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shutdown_q <= 1'b0;
    end else if (starting) begin
      shutdown_q <= 1'b0;
    end else if (cs_rise & last_frame & arm_q) begin
      shutdown_q <= 1'b1;
    end else if (is_mode & mode_shdn & ~mode_start & (~busy_q | last_frame)) begin
      // RULE9 shutdown at last readout
      shutdown_q <= 1'b1;
    end
  end

  // Output validity after a configuration word inside a sequence.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      invalid_q <= 1'b0;
    end else if (is_mode) begin
      invalid_q <= 1'b0;
    end else if (is_cfg & busy_q) begin
      // RULE15 mark later frames invalid
      invalid_q <= 1'b1;
    end
  end

  // Output shifter: loaded at frame start, shifted on falling serial clock.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_q <= 16'h0000;
      conv_req_q <= 1'b0;
    end else begin
      conv_req_q <= converting;
      if (cs_fall) begin
        tx_q <= 16'h0000;
      end else if (conv_req_q) begin
        tx_q <= conv_result;
      end else if (in_frame & sclk_fall) begin
        tx_q <= {tx_q[14:0], 1'b0};
      end
    end
  end

  // The pin drives zero while data is marked invalid.
  assign link.dout = tx_q[15] & ~invalid_q;
  assign conv_req = conv_req_q;
  assign conv_chan = chan_q;
  assign upper_mask = upper_q;
  assign lower_mask = lower_q;
  assign sequence_length_field = length_q;
  assign seq_busy = busy_q;
  assign out_invalid = invalid_q;
  assign shutdown = shutdown_q;
endmodule : scan_cfg_device
`default_nettype wire

// file: rtl/scan_cfg_host.sv
// Host end: Avalon-MM registers that send one serial word per frame.
`timescale 1ns/1ps
`default_nettype none
module scan_cfg_host (
  input wire logic clock, // System clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic [3:0] address, // Avalon byte address.
  input wire logic read, // Avalon read.
  input wire logic write, // Avalon write.
  input wire logic [31:0] writedata, // Avalon write data.
  output logic [31:0] readdata, // Avalon read data.
  output logic waitrequest, // Avalon wait request.
  scan_link_if.host link // Serial link to the converter.
);
  typedef enum logic [2:0] {IDLE, BIT_LOW, BIT_HIGH, TAIL, GAP} state_t;
  state_t state_q;
  logic [3:0] div_q;
  logic [3:0] bit_q;
  logic [15:0] tx_q, rx_q, rx_hold_q;
  logic sclk_q, cs_n_q, rx_ready_q;
  logic dout_s1_q, dout_s2_q;

  wire half_done = (div_q == scan_cfg_pkg::HALF_LAST);
  wire busy = (state_q != IDLE);
  wire sel_tx = (address == scan_cfg_pkg::TX_OFFSET);
  wire sel_status = (address == scan_cfg_pkg::STATUS_OFFSET);
  wire sel_rx = (address == scan_cfg_pkg::RX_OFFSET);
  // A word is refused by stalling the bus until the frame and its gap are over.
  wire tx_accept = write & sel_tx & ~busy;
  wire frame_end = (state_q == GAP) & half_done;
  wire [31:0] status_word = {30'h0, rx_ready_q, busy};

  // Avalon answer: no wait except a send while a frame or its gap runs.
  assign waitrequest = write & sel_tx & busy;
  assign readdata = sel_status ? status_word : (sel_rx ? {16'h0000, rx_hold_q} : 32'h0);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {dout_s1_q, dout_s2_q} <= 2'h0;
    end else begin
      {dout_s1_q, dout_s2_q} <= {link.dout, dout_s1_q};
    end
  end

  // RULE16 frame of sixteen bits
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= IDLE;
      div_q <= 4'h0;
      bit_q <= 4'h0;
      tx_q <= 16'h0000;
      rx_q <= 16'h0000;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      div_q <= (half_done | state_q == IDLE) ? 4'h0 : 4'(div_q + 4'h1);
      unique case (state_q)
        IDLE: begin
          if (tx_accept) begin
            tx_q <= writedata[15:0];
            bit_q <= 4'h0;
            cs_n_q <= 1'b0;
            state_q <= BIT_LOW;
          end
        end
        BIT_LOW: begin
          if (half_done) begin
            sclk_q <= 1'b1;
            rx_q <= {rx_q[14:0], dout_s2_q};
            state_q <= BIT_HIGH;
          end
        end
        BIT_HIGH: begin
          if (half_done) begin
            sclk_q <= 1'b0;
            tx_q <= {tx_q[14:0], 1'b0};
            bit_q <= 4'(bit_q + 4'h1);
            state_q <= (bit_q == 4'hf) ? TAIL : BIT_LOW;
          end
        end
        TAIL: begin
          if (half_done) begin
            cs_n_q <= 1'b1;
            state_q <= GAP;
          end
        end
        GAP: begin
          if (half_done) begin
            state_q <= IDLE;
          end
        end
      endcase
    end
  end

  // Received word flag: a new word wins over the clearing read.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_hold_q <= 16'h0000;
      rx_ready_q <= 1'b0;
    end else if (frame_end) begin
      rx_hold_q <= rx_q;
      rx_ready_q <= 1'b1;
    end else if (read & sel_rx) begin
      rx_ready_q <= 1'b0;
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.din = tx_q[15];
endmodule : scan_cfg_host
`default_nettype wire

// file: test/scan_link_props.sv
// Wire-level checks on the serial link joining the host and converter ends.
`timescale 1ns/1ps
`default_nettype none
module scan_link_props (
  input wire logic clock, // System clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic sclk, // Serial clock from the host.
  input wire logic cs_n, // Frame select, active low.
  input wire logic din, // Host to converter data.
  input wire logic dout // Converter to host data.
);
  logic sclk_q;
  logic [4:0] rises_q;
  logic [4:0] rises_d;
  wire logic rise_seen = sclk && !sclk_q;

  // Count serial clock rises per frame; idle select clears it so each frame starts at zero.
  assign rises_d = cs_n ? 5'h00 : rises_q + {4'h0, rise_seen};

  // History of the serial clock and the running count.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclk_q <= 1'b0;
      rises_q <= 5'h00;
    end else begin
      sclk_q <= sclk;
      rises_q <= rises_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // Framing, data stability and half-period timing of the serial word.
  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside a frame");
  a_din_steady_high: assert property (sclk |-> $stable(din))
    else $error("data changed while serial clock high");
  a_high_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high phase not eight cycles");
  a_low_half: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("serial clock low phase too short");
  a_frame_lead: assert property ($fell(cs_n) |-> !sclk [*8] ##1 sclk)
    else $error("first clock rise not eight cycles after select");
  a_frame_gap: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("gap between frames too short");
  a_sixteen_bits: assert property ($rose(cs_n) |-> rises_q == 5'h10)
    else $error("frame did not carry sixteen clocks");
  a_select_steady: assert property ($changed(cs_n) |-> !sclk && !$past(sclk))
    else $error("select moved while serial clock high");

  // Main traffic kinds seen on the link.
  c_frame_done: cover property ($rose(cs_n));
  c_result_bit: cover property (!cs_n && $rose(dout));
  c_config_word: cover property ($fell(cs_n) ##1 din);
endmodule : scan_link_props
`default_nettype wire

// file: test/adc_scan_sequence_config_tb.sv
// Self-checking bench: host and converter ends joined by the serial link.
`timescale 1ns/1ps
`default_nettype none
module adc_scan_sequence_config_tb;
  logic clock;
  logic rstn;
  logic [3:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic conv_req;
  logic [3:0] conv_chan;
  logic [15:0] conv_result;
  logic [7:0] upper_mask;
  logic [7:0] lower_mask;
  logic [7:0] seq_len;
  logic seq_busy;
  logic out_invalid;
  logic shutdown;
  logic [3:0] chans[$];
  int n_fail;
  int comparisons;

  scan_link_if link ();
  scan_cfg_host i_scan_cfg_host (.clock(clock), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .link(link));
  scan_cfg_device i_scan_cfg_device (.clock(clock), .rstn(rstn), .link(link),
    .conv_req(conv_req), .conv_chan(conv_chan), .conv_result(conv_result),
    .upper_mask(upper_mask), .lower_mask(lower_mask), .sequence_length_field(seq_len),
    .seq_busy(seq_busy), .out_invalid(out_invalid), .shutdown(shutdown));
  scan_link_props i_scan_link_props (.clock(clock), .rstn(rstn), .sclk(link.sclk),
    .cs_n(link.cs_n), .din(link.din), .dout(link.dout));

  // Stand-in converter core: the channel sits in the result so a wrong scan shows up.
  assign conv_result = {4'hc, conv_chan, 8'h5a};

  // Record every requested channel in order.
  always @(posedge clock) begin
    if (conv_req === 1'b1) begin
      chans.push_back(conv_chan);
    end
  end

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Packs up to four recorded channels, newest in the low nibble.
  task automatic chk_scan(input int n, input logic [15:0] exp);
    logic [15:0] got;
    got = 16'h0000;
    foreach (chans[i]) got = {got[11:0], chans[i]};
    chk(got, exp);
    chk(16'(chans.size()), 16'(n));
  endtask : chk_scan

  // One bus cycle; the request holds until waitrequest is seen low at an edge.
  task automatic av_cycle(input logic [3:0] a, input logic wr, input logic [15:0] d,
                          output logic [31:0] q);
    @(posedge clock);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= {16'h0000, d};
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : av_cycle

  // Sends one word and waits for the host to go idle, frame gap included.
  task automatic send(input logic [15:0] w);
    logic [31:0] q;
    av_cycle(scan_cfg_pkg::TX_OFFSET, 1'b1, w, q);
    do av_cycle(scan_cfg_pkg::STATUS_OFFSET, 1'b0, 16'h0000, q); while (q[0] !== 1'b0);
  endtask : send

  // Unused low bits are set on purpose; the converter must ignore them.
  task automatic cfg(input logic [4:0] code, input logic [7:0] field);
    send({code, field, 3'h7});
  endtask : cfg

  task automatic rx_chk(input logic [15:0] exp);
    logic [31:0] q;
    av_cycle(scan_cfg_pkg::RX_OFFSET, 1'b0, 16'h0000, q);
    chk(q[15:0], exp);
  endtask : rx_chk

  task automatic t_reset();
    logic [31:0] q;
    av_cycle(4'hc, 1'b1, 16'hffff, q);
    av_cycle(4'hc, 1'b0, 16'h0000, q);
    chk(q[15:0], 16'h0000);
    chk({upper_mask, lower_mask}, 16'h0000);
    chk({seq_len, 5'h0, seq_busy, out_invalid, shutdown}, 16'h0000);
  endtask : t_reset

  task automatic t_route();
    cfg(scan_cfg_pkg::UPPER_MASK_CODE, 8'h81);
    chk({upper_mask, lower_mask}, 16'h8100);
    cfg(scan_cfg_pkg::LOWER_MASK_CODE, 8'h42);
    chk({upper_mask, lower_mask}, 16'h8142);
    cfg(scan_cfg_pkg::SEQUENCE_CODE, 8'h03);
    chk({seq_len, lower_mask}, 16'h0342);
    cfg(5'h17, 8'hff);
    chk({upper_mask, lower_mask}, 16'h8142);
    chk({seq_len, 8'h00}, 16'h0300);
    send(16'h27f8);
    chk({upper_mask, lower_mask}, 16'h8142);
    chk({15'h0, shutdown}, 16'h0001);
  endtask : t_route

  // Single conversion, shutdown ordered while its result is read.
  task automatic t_single();
    cfg(scan_cfg_pkg::SEQUENCE_CODE, 8'h00);
    send(16'h4000);
    chans.delete();
    send(16'h2000);
    rx_chk(16'hc15a);
    chk_scan(1, 16'h0001);
    chk({14'h0, seq_busy, shutdown}, 16'h0001);
  endtask : t_single

  // Configuration mid-sequence: scan keeps its latched masks, output goes invalid.
  task automatic t_mid_cfg();
    cfg(scan_cfg_pkg::SEQUENCE_CODE, 8'h03);
    send(16'h4000);
    chans.delete();
    for (int i = 0; i < 4; i++) begin
      cfg(scan_cfg_pkg::LOWER_MASK_CODE, 8'h01);
      rx_chk((i == 0) ? 16'hc15a : 16'h0000);
    end
    chk_scan(4, 16'h168f);
    chk({upper_mask, lower_mask}, 16'h8101);
    chk({13'h0, seq_busy, out_invalid, shutdown}, 16'h0002);
    send(16'h0000);
    chk({15'h0, out_invalid}, 16'h0000);
  endtask : t_mid_cfg

  // Mode word mid-sequence: the running frame finishes, the stop lands at the next frame.
  task automatic t_mid_mode();
    send(16'h4000);
    chans.delete();
    send(16'h0000);
    chk({14'h0, seq_busy, out_invalid}, 16'h0002);
    rx_chk(16'hc05a);
    send(16'h0000);
    chk_scan(1, 16'h0000);
    chk({15'h0, seq_busy}, 16'h0000);
  endtask : t_mid_mode

  // Start with shutdown armed ends in shutdown; a start with no channel enabled is dropped.
  task automatic t_auto_shdn();
    cfg(scan_cfg_pkg::SEQUENCE_CODE, 8'h00);
    send(16'h6000);
    chans.delete();
    cfg(scan_cfg_pkg::UPPER_MASK_CODE, 8'h00);
    rx_chk(16'hc05a);
    chk({13'h0, seq_busy, out_invalid, shutdown}, 16'h0003);
    cfg(scan_cfg_pkg::LOWER_MASK_CODE, 8'h00);
    send(16'h4000);
    send(16'h4000);
    chk_scan(1, 16'h0000);
    chk({13'h0, seq_busy, out_invalid, shutdown}, 16'h0001);
  endtask : t_auto_shdn

  task automatic print_verdict();
    $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  // Twenty-four frames of some 290 cycles each fit well inside this span.
  initial begin
    #100000;
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end

  initial begin
    rstn = 1'b0;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    t_reset();
    t_route();
    t_single();
    t_mid_cfg();
    t_mid_mode();
    t_auto_shdn();
    // A second reset in mid-run must clear every stored setting again.
    rstn <= 1'b0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    t_reset();
    print_verdict();
  end
endmodule : adc_scan_sequence_config_tb
`default_nettype wire
